// >>> rtl/pewc_pkg.sv
// shared constants for the program array write control
package pewc_pkg;
  // ==========================================================
  // memory map seen by the cpu core
  // ==========================================================
  localparam logic [15:0] ARRAY_BASE = 16'h7000; // first array byte
  localparam logic [15:0] ARRAY_LAST = 16'h7fff; // last array byte
  localparam logic [15:0] CTRL_ADDR  = 16'h101c; // control register
  localparam int          ARRAY_AW   = 12;       // 4 kbyte array
  localparam int          ARRAY_WORDS = 4096;
  // ==========================================================
  // control register layout and commands
  // ==========================================================
  localparam int         EXE_BIT    = 0;      // program_execute_bit
  localparam int         W1_BIT     = 1;      // write_ones_select
  localparam int         AP_BIT     = 2;      // whole_array_program_bit
  localparam int         BUSY_BIT   = 7;      // read-only activity flag
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] CMD_ONES   = 8'h03;
  localparam logic [7:0] CMD_ZEROS  = 8'h01;
  localparam logic [7:0] CMD_FILL0  = 8'h05;
  localparam logic [7:0] CMD_FILL1  = 8'h07;
  localparam logic [7:0] CMD_CLEAR  = 8'h00;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int T_PROG_NS     = 10_000_000; // programming delay, 10 ms
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_CYCLES   = (T_PROG_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // ==========================================================
  // host apb register map
  // ==========================================================
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CMD_ADDR_LSB = 0;   // [11:0] array offset
  localparam int CMD_DATA_LSB = 12;  // [19:12] data byte
  localparam int CMD_OP_LSB   = 20;  // [22:20] operation
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_RD_LSB    = 8;   // [15:8] last read byte
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_ONES  = 3'h1;
  localparam logic [2:0] OP_ZEROS = 3'h2;
  localparam logic [2:0] OP_FILL0 = 3'h3;
  localparam logic [2:0] OP_FILL1 = 3'h4;
endpackage : pewc_pkg

// >>> rtl/pewc_if.sv
// memory bus between the cpu side and the program array block
`timescale 1ns/1ps
interface pewc_if;
  logic [15:0] mem_addr;   // byte address
  logic [7:0]  mem_wdata;  // write byte
  logic        mem_wr;     // one-cycle write strobe
  logic        mem_rd;     // one-cycle read strobe
  logic [7:0]  mem_rdata;  // read byte, valid the cycle after mem_rd
  logic        low_power;  // halt or standby level
  // documented device end
  modport device (
    input  mem_addr,
    input  mem_wdata,
    input  mem_wr,
    input  mem_rd,
    input  low_power,
    output mem_rdata
  );
  // cpu end
  modport cpu (
    output mem_addr,
    output mem_wdata,
    output mem_wr,
    output mem_rd,
    output low_power,
    input  mem_rdata
  );
endinterface : pewc_if

// >>> rtl/pewc_device.sv
// program nonvolatile array with its programming control register
`timescale 1ns/1ps
module pewc_device
  import pewc_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES // programming delay
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic mode_control_pin_i, // 1 = high programming level
  output logic      protect_override_mode_o,
  output logic      busy_o,
  pewc_if.device    bus
);
  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,  // no programming
    ST_PROG  = 3'b010,  // execute bit held
    ST_SWEEP = 3'b100   // whole-array fill running
  } pewc_dev_state_e;

  typedef struct packed {
    pewc_dev_state_e         state;
    logic [2:0]              ctrl;      // control register bits
    logic                    po;        // protect_override_mode
    logic [ARRAY_AW-1:0]     lat_addr;  // latched target
    logic [7:0]              lat_data;  // latched byte
    logic                    prog_w1;   // mode caught at start
    logic                    prog_ap;   // whole-array caught at start
    logic [31:0]             cnt;       // programming time elapsed
    logic                    timed;     // full delay has passed
    logic [ARRAY_AW-1:0]     sweep;     // fill index
    logic [7:0]              rdata;     // registered read data
  } pewc_dev_s;

  pewc_dev_s r;       // registered state
  pewc_dev_s next_r;  // next state

  logic [7:0]          mem [ARRAY_WORDS]; // no reset: nonvolatile
  logic                mem_we;            // array write strobe
  logic [ARRAY_AW-1:0] mem_wa;            // array write index
  logic [7:0]          mem_wd;            // array write byte
  logic [7:0]          old_byte;          // stored byte at target
  logic                hit_array;         // address in array
  logic                hit_ctrl;          // address is control
  logic [ARRAY_AW-1:0] acc_idx;           // array index of access

  // ==========================================================
  // address decode
  // ==========================================================
  always_comb begin
    hit_array = (bus.mem_addr >= ARRAY_BASE) &&
                (bus.mem_addr <= ARRAY_LAST);
    hit_ctrl  = (bus.mem_addr == CTRL_ADDR);
    acc_idx   = bus.mem_addr[ARRAY_AW-1:0];
    old_byte  = mem[r.lat_addr];
  end

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_wa = r.lat_addr;
    mem_wd = r.lat_data;
    // override follows the mode pin once out of reset
    next_r.po = mode_control_pin_i;

    // read path, answered one cycle after the strobe
    if (bus.mem_rd && !bus.low_power) begin
      if (hit_ctrl) begin
        next_r.rdata = 8'h00;
        next_r.rdata[2:0] = r.ctrl;
        next_r.rdata[BUSY_BIT] = (r.state != ST_IDLE);
      end else if (hit_array) begin
        if (r.state == ST_PROG && r.po) begin
          next_r.rdata = r.lat_data;
        end else if (r.state == ST_SWEEP) begin
          // fill byte is what the array is becoming
          next_r.rdata = {8{r.prog_w1}};
        end else begin
          // ordinary read straight from the array
          next_r.rdata = mem[acc_idx];
        end
      end else begin
        // unmapped for this block: drive zero
        next_r.rdata = 8'h00;
      end
    end

    // an array write only latches address and byte
    if (bus.mem_wr && hit_array && !bus.low_power &&
        r.state == ST_IDLE) begin
      // data staged for the following command
      next_r.lat_addr = acc_idx;
      next_r.lat_data = bus.mem_wdata;
    end

    if (bus.mem_wr && hit_ctrl && !bus.low_power) begin
      next_r.ctrl[EXE_BIT] = bus.mem_wdata[EXE_BIT];
      next_r.ctrl[W1_BIT]  = bus.mem_wdata[W1_BIT];
      next_r.ctrl[AP_BIT]  = bus.mem_wdata[AP_BIT];
    end

    case (r.state)
      ST_IDLE: begin
        if (next_r.ctrl[EXE_BIT] && !r.ctrl[EXE_BIT] && r.po) begin
          next_r.state   = ST_PROG;
          next_r.prog_w1 = next_r.ctrl[W1_BIT];
          next_r.prog_ap = next_r.ctrl[AP_BIT];
          next_r.cnt     = 32'h0;
          next_r.timed   = 1'b0;
        end
      end
      ST_PROG: begin
        // count the programming delay, saturating
        if (!r.timed) begin
          next_r.cnt = r.cnt + 32'h1;
          if (r.cnt >= PROG_CYC - 1) begin
            next_r.timed = 1'b1;
          end
        end
        if (!next_r.ctrl[EXE_BIT]) begin
          next_r.state = ST_IDLE;
          if (r.timed && r.prog_ap) begin
            // whole array filled one byte a cycle
            next_r.state = ST_SWEEP;
            next_r.sweep = '0;
          end else if (r.timed) begin
            mem_we = 1'b1;
            mem_wd = r.prog_w1 ? (old_byte | r.lat_data)
                               : (old_byte & r.lat_data);
          end
          // a cut-short delay leaves the byte untouched
        end
      end
      ST_SWEEP: begin
        // zeros or ones per the ones select
        mem_we = 1'b1;
        mem_wa = r.sweep;
        mem_wd = {8{r.prog_w1}};
        next_r.sweep = r.sweep + 1'b1;
        if (r.sweep == ARRAY_AW'(ARRAY_WORDS - 1)) begin
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    if (!r.po && r.state == ST_PROG) begin
      next_r.state = ST_IDLE;
      mem_we = 1'b0;
    end

    // halt or standby stops everything, clears control
    if (bus.low_power) begin
      next_r.state = ST_IDLE;
      next_r.ctrl  = CTRL_RESET;
      mem_we       = 1'b0;
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.state    <= ST_IDLE;
      r.ctrl     <= CTRL_RESET;
      r.po       <= 1'b0;
      r.lat_addr <= '0;
      r.lat_data <= 8'h00;
      r.prog_w1  <= 1'b0;
      r.prog_ap  <= 1'b0;
      r.cnt      <= 32'h0;
      r.timed    <= 1'b0;
      r.sweep    <= '0;
      r.rdata    <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // array storage, kept out of reset like real cells
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign bus.mem_rdata            = r.rdata;
  assign protect_override_mode_o  = r.po;
  assign busy_o                   = (r.state != ST_IDLE);
endmodule : pewc_device

// >>> rtl/pewc_cpu.sv
// cpu-side sequencer: apb registers in, programming sequence out
`timescale 1ns/1ps
module pewc_cpu
  import pewc_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES // hold time per command
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        low_power_i, // halt or standby request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pewc_if.cpu              bus
);
  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_DATA  = 6'b000010, // byte write to target
    S_CMD   = 6'b000100, // command write
    S_WAIT  = 6'b001000, // hold for the delay
    S_POLL  = 6'b010000, // read control until not busy
    S_CHECK = 6'b100000  // look at answer
  } pewc_cpu_state_e;

  typedef struct packed {
    pewc_cpu_state_e state;
    logic [11:0]     addr;    // array offset
    logic [7:0]      data;    // byte to program
    logic [2:0]      op;      // requested operation
    logic [31:0]     cnt;     // delay counter
    logic            done;    // sticky completion
    logic [7:0]      rd_byte; // last byte read
    logic [15:0]     a;       // bus address
    logic [7:0]      wd;      // bus write data
    logic            wr;      // bus write strobe
    logic            rd;      // bus read strobe
    logic            lp;      // low power level
    logic [31:0]     prdata;
    logic            pslverr;
  } pewc_cpu_s;

  pewc_cpu_s r;       // registered state
  pewc_cpu_s next_r;  // next state
  logic      setup;   // apb setup cycle

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    next_r    = r;
    setup     = psel && !penable;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    next_r.lp = low_power_i;

    // apb slave: answer prepared in setup, given in access
    if (setup) begin
      next_r.prdata  = 32'h0;
      next_r.pslverr = 1'b0;
      if (paddr == REG_CMD) begin
        if (pwrite && r.state == S_IDLE) begin
          next_r.addr  = pwdata[CMD_ADDR_LSB +: 12];
          next_r.data  = pwdata[CMD_DATA_LSB +: 8];
          next_r.op    = pwdata[CMD_OP_LSB +: 3];
          next_r.done  = 1'b0;
          next_r.state = (pwdata[CMD_OP_LSB +: 3] >= OP_FILL0) ?
                         S_CMD : S_DATA;
        end
      end else if (paddr == REG_STATUS) begin
        next_r.prdata[ST_BUSY_BIT]  = (r.state != S_IDLE);
        next_r.prdata[ST_DONE_BIT]  = r.done;
        next_r.prdata[ST_RD_LSB +: 8] = r.rd_byte;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end

    case (r.state)
      S_IDLE: begin
      end
      S_DATA: begin
        // byte goes to the target, or read request
        next_r.a  = ARRAY_BASE | {4'h0, r.addr};
        next_r.wd = r.data;
        if (r.op == OP_READ) begin
          next_r.rd    = 1'b1;
          next_r.state = S_CHECK;
        end else begin
          next_r.wr    = 1'b1;
          next_r.state = S_CMD;
        end
      end
      S_CMD: begin
        next_r.a  = CTRL_ADDR;
        next_r.wr = 1'b1;
        case (r.op)
          OP_ONES:  next_r.wd = CMD_ONES;
          OP_ZEROS: next_r.wd = CMD_ZEROS;
          OP_FILL0: next_r.wd = CMD_FILL0;
          default:  next_r.wd = CMD_FILL1;
        endcase
        next_r.cnt   = 32'h0;
        next_r.state = S_WAIT;
      end
      S_WAIT: begin
        // command held for the full delay, then 00h
        next_r.cnt = r.cnt + 32'h1;
        // one spare cycle: the device sees the command a cycle late
        if (r.cnt > PROG_CYC) begin
          next_r.a     = CTRL_ADDR;
          next_r.wd    = CMD_CLEAR;
          next_r.wr    = 1'b1;
          next_r.state = S_POLL;
        end
      end
      S_POLL: begin
        // wait out any whole-array fill
        next_r.a     = CTRL_ADDR;
        next_r.rd    = 1'b1;
        next_r.state = S_CHECK;
      end
      S_CHECK: begin
        // answer arrives now, one cycle after the strobe
        if (r.rd) begin
          // strobe still out: the device registers its answer now
          next_r.state = S_CHECK;
        end else if (r.op == OP_READ) begin
          next_r.rd_byte = bus.mem_rdata;
          next_r.done    = 1'b1;
          next_r.state   = S_IDLE;
        end else if (bus.mem_rdata[BUSY_BIT]) begin
          next_r.state = S_POLL;
        end else begin
          next_r.done  = 1'b1;
          next_r.state = S_IDLE;
        end
      end
      default: begin
        next_r.state = S_IDLE;
      end
    endcase

    // entering low power drops the sequence
    if (low_power_i) begin
      next_r.state = S_IDLE;
      next_r.wr    = 1'b0;
      next_r.rd    = 1'b0;
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{state: S_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // this sequencer reads from the array only for the read operation
  assign bus.mem_addr  = r.a;
  assign bus.mem_wdata = r.wd;
  assign bus.mem_wr    = r.wr;
  assign bus.mem_rd    = r.rd;
  assign bus.low_power = r.lp;
  assign prdata        = r.prdata;
  assign pslverr       = r.pslverr && penable;
  assign pready        = penable;
endmodule : pewc_cpu

// >>> test/pewc_chk.sv
// concurrent checks on the memory bus between the cpu end and the device
`timescale 1ns/1ps
module pewc_chk
  import pewc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        mode_control_pin_i,
  input wire logic        protect_override_mode_o,
  input wire logic        busy_o,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic [7:0]  mem_rdata,
  input wire logic        low_power
);
  // ==========================================================
  // helper: shadow of the stored control bits
  // ==========================================================
  logic [2:0] ctl_q;  // last accepted control byte, low bits
  logic       ctl_wr; // accepted write to the control address
  assign ctl_wr = mem_wr && (mem_addr == CTRL_ADDR) && !low_power;
  // halt clears the bits, so the shadow must clear too
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q <= CTRL_RESET;
    end else if (low_power) begin
      ctl_q <= CTRL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= mem_wdata[2:0];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // command steps
  // ==========================================================
  sequence s_start;
    ctl_wr && mem_wdata[EXE_BIT] && !busy_o;
  endsequence
  sequence s_clear;
    ctl_wr && (mem_wdata == CMD_CLEAR) && ctl_q[EXE_BIT];
  endsequence
  // ==========================================================
  // assertions
  // ==========================================================
  AST_OVR_TRACK: assert property (
    1'b1 |=> protect_override_mode_o == $past(mode_control_pin_i))
    else $error("override flag does not follow the mode pin");
  AST_NO_OVR_BLOCK: assert property (
    s_start ##0 !protect_override_mode_o |=> !busy_o)
    else $error("programming started without override");
  AST_CMD_START: assert property (
    s_start ##0 protect_override_mode_o |=> busy_o)
    else $error("execute command did not start programming");
  AST_CMD_HOLD: assert property (
    busy_o && ctl_q[EXE_BIT] && protect_override_mode_o && !low_power
    && !ctl_wr |=> busy_o)
    else $error("programming ended while command held");
  AST_LP_ABORT: assert property (
    low_power |=> !busy_o)
    else $error("low power did not abort programming");
  AST_SINGLE_END: assert property (
    s_clear ##0 !ctl_q[AP_BIT] |=> !busy_o)
    else $error("clear did not end byte programming");
  AST_FILL_RUN: assert property (
    s_clear ##0 (ctl_q[AP_BIT] && busy_o) |=> busy_o [*8])
    else $error("whole array fill stopped early");
  AST_CTRL_READ: assert property (
    mem_rd && (mem_addr == CTRL_ADDR) && !low_power
    |=> mem_rdata[2:0] == ctl_q)
    else $error("control readback differs from stored bits");
endmodule : pewc_chk

// >>> test/program_eeprom_write_control_tb_top.sv
// self-checking bench joining the cpu end and the device end
`timescale 1ns/1ps
module program_eeprom_write_control_tb_top;
  import pewc_pkg::*;
  localparam int PCYC = 8; // short programming delay for simulation
  // ==========================================================
  // signals
  // ==========================================================
  logic        core_clk_i; // 20 mhz clock
  logic        rst_n_i;    // async reset, active low
  logic        mode_pin;   // high programming level
  logic        lp;         // halt or standby request
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ovr;        // override flag seen
  logic        busy;       // device activity
  logic [31:0] rdat;       // data of the last transfer
  logic        serr;       // error of the last transfer
  logic [30:0] rows [0:7]; // {expected byte, command word}
  int          err_count;
  int          n_checks;
  pewc_if mbus ();
  pewc_device #(.PROG_CYC(PCYC)) i_pewc_device (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mode_control_pin_i(mode_pin), .protect_override_mode_o(ovr),
    .busy_o(busy), .bus(mbus.device));
  pewc_cpu #(.PROG_CYC(PCYC)) i_pewc_cpu (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .low_power_i(lp),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(mbus.cpu));
  pewc_chk i_pewc_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mode_control_pin_i(mode_pin), .protect_override_mode_o(ovr),
    .busy_o(busy), .mem_addr(mbus.mem_addr), .mem_wdata(mbus.mem_wdata),
    .mem_wr(mbus.mem_wr), .mem_rd(mbus.mem_rd),
    .mem_rdata(mbus.mem_rdata), .low_power(mbus.low_power));
  // clock generator
  always #25 core_clk_i = ~core_clk_i;
  // ==========================================================
  // tasks
  // ==========================================================
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // poll status until done; bounded so a hang shows up as a mismatch
  task automatic wait_done();
    int n;
    n = 0;
    rdat = '0;
    while (rdat[ST_DONE_BIT] !== 1'b1 && n < 3000) begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    if (n >= 3000) check("done_wait", 32'h1, 32'h0);
  endtask : wait_done
  // issue one command word and read the byte back at its offset
  task automatic run_and_read(input logic [22:0] w, input logic [7:0] e);
    apb(1'b1, REG_CMD, {9'h000, w});
    wait_done();
    apb(1'b1, REG_CMD, {9'h000, OP_READ, 8'h00, w[11:0]});
    wait_done();
    check("array_byte", {24'h0, e}, {24'h0, rdat[15:8]});
  endtask : run_and_read
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // watchdog: fills need about 8200 cycles, allow far more
  initial begin
    #(40000 * 50);
    err_count++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    core_clk_i = 1'b0;
    rst_n_i    = 1'b0;
    mode_pin   = 1'b1;
    lp         = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = '0;
    err_count  = 0;
    n_checks   = 0;
    // ordinary cases: fills, ones, zeros, boundary offsets
    rows = '{{8'hff, OP_FILL1, 8'h00, 12'h000},
             {8'h5a, OP_ZEROS, 8'h5a, 12'h123},
             {8'hdb, OP_ONES,  8'h81, 12'h123},
             {8'h0f, OP_ZEROS, 8'h0f, 12'hfff},
             {8'hf0, OP_ZEROS, 8'hf0, 12'h000},
             {8'h00, OP_FILL0, 8'h00, 12'h000},
             {8'ha5, OP_ONES,  8'ha5, 12'h7ff},
             {8'h00, OP_READ,  8'h00, 12'hfff}};
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    check("busy_after_reset", 32'h0, {31'h0, busy});
    apb(1'b0, REG_STATUS, 32'h0);
    check("status_reset", 32'h0, {30'h0, rdat[1:0]});
    for (int i = 0; i < 8; i++) begin
      run_and_read(rows[i][22:0], rows[i][30:23]);
    end
    // unmapped register place
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, serr});
    check("unmapped_data", 32'h0, rdat);
    // no override: command must leave the byte alone
    mode_pin <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    check("override_off", 32'h0, {31'h0, ovr});
    run_and_read({OP_ONES, 8'hff, 12'h123}, 8'h00);
    mode_pin <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    // second command while busy is refused without error
    apb(1'b1, REG_CMD, {9'h000, OP_ZEROS, 8'h0f, 12'h7ff});
    apb(1'b1, REG_CMD, {9'h000, OP_ONES, 8'hff, 12'h000});
    check("refused_err", 32'h0, {31'h0, serr});
    wait_done();
    run_and_read({OP_READ, 8'h00, 12'h7ff}, 8'h05);
    run_and_read({OP_READ, 8'h00, 12'h000}, 8'h00);
    // halt in mid-programming aborts; the byte is then undefined
    apb(1'b1, REG_CMD, {9'h000, OP_ZEROS, 8'h00, 12'h123});
    for (int n = 0; n < 20 && busy !== 1'b1; n++) @(posedge core_clk_i);
    check("busy_before_halt", 32'h1, {31'h0, busy});
    lp <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check("busy_in_halt", 32'h0, {31'h0, busy});
    lp <= 1'b0;
    // an aborted sequence never reports done
    apb(1'b0, REG_STATUS, 32'h0);
    check("status_after_halt", 32'h0, {30'h0, rdat[1:0]});
    check("busy_after_halt", 32'h0, {31'h0, busy});
    // programming works again once out of halt
    run_and_read({OP_ONES, 8'h11, 12'h456}, 8'h11);
    complete_run();
  end
endmodule : program_eeprom_write_control_tb_top
